// [rtl/led_ctrl_pkg.sv]
// Constants shared by the LED regulator control plane.
// Assumes a single 100 MHz core clock and an analog front end outside the core.
// What this block does
// RL1: Feedback is the participating channel with the lowest voltage.
// RL2: Low-current channels on the alternate supply never serve as feedback.
// RL3: High-current channels take a 7-bit, 128-step code up to 25.25mA.
// RL4: Low-current channels take a 5-bit, 32-step code, 50uA to 5.0mA.
// RL5: Each high-current channel has up and down ramp timers, eight settings.
// RL6: Each low-current channel has up and down ramp timers, eight settings.
// RL7: Each low-current channel has blink on/off timers and a blink disable.
// RL8: Each of the five channels switches on or off independently.
// RL9: The device answers I2C write address 0x9A and read address 0x9B.
// RL10: Open/short, overvoltage, thermal, diode faults stay readable.
// RL11: Pulse-skip mode turns the switch on for 20ns, then off until needed.
// RL12: Level, on/off, ramp and blink timers follow host-written settings.
// RL13: Shutdown clears all state but synchronisers, bus shift register and read/write flag, and keeps converter and channels off.
// RL14: From standby the converter starts once any channel is enabled.
// RL15: A disabled channel is excluded from the feedback selection.
package led_ctrl_pkg;
	localparam int NUM_CHAN = 5;
	localparam int NUM_HC = 2;
	localparam int NUM_LC = 3;
	localparam int HC_LEVEL_W = 7;
	localparam int LC_LEVEL_W = 5;
	localparam int TIMER_SEL_W = 3;
	localparam int VOLT_W = 8;
	localparam int STATUS_W = 8;
	localparam int TICK_W = 24;
	localparam logic [7:0] I2C_ADDR_WRITE = 8'h9a;
	localparam logic [7:0] I2C_ADDR_READ = 8'h9b;
	localparam logic [3:0] I2C_BITS_PER_BYTE = 4'h8;
	localparam int STAT_OVP_POS = 5;
	localparam int STAT_THERMAL_POS = 6;
	localparam int STAT_DIODE_POS = 7;
	localparam logic [STATUS_W-1:0] STATUS_RESET = 8'h00;
	localparam int CLK_PERIOD_NS = 10;
	localparam int MIN_ON_NS = 20;
	localparam int MIN_ON_CYCLES =
		(MIN_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RAMP_BASE_US = 10;
	localparam int RAMP_BASE_CYCLES = RAMP_BASE_US * 1000 / CLK_PERIOD_NS;
	localparam int BLINK_BASE_US = 1000;
	localparam int BLINK_BASE_CYCLES = BLINK_BASE_US * 1000 / CLK_PERIOD_NS;
	typedef enum logic [3:0] {
		I2C_IDLE = 4'b0001,
		I2C_ADDR = 4'b0010,
		I2C_ACK = 4'b0100,
		I2C_DATA = 4'b1000
	} i2c_state_type;
	typedef enum logic [1:0] {
		SKIP_IDLE = 2'b01,
		SKIP_ON = 2'b10
	} skip_state_type;
endpackage

// [rtl/channel_sequencer.sv]
// One current channel: ramps the level code toward its target and blinks.
// Assumes tick bases from the top and a synchronous hold during shutdown.
`timescale 1ns/1ns
module channel_sequencer #(
	parameter int LEVEL_W = 5,
	parameter bit HAS_BLINK = 1'b0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic hold_in,
	input wire logic enable_in,
	input wire logic [LEVEL_W-1:0] target_in,
	input wire logic [led_ctrl_pkg::TIMER_SEL_W-1:0] ramp_up_sel_in,
	input wire logic [led_ctrl_pkg::TIMER_SEL_W-1:0] ramp_down_sel_in,
	input wire logic blink_enable_in,
	input wire logic [led_ctrl_pkg::TIMER_SEL_W-1:0] blink_on_sel_in,
	input wire logic [led_ctrl_pkg::TIMER_SEL_W-1:0] blink_off_sel_in,
	input wire logic [led_ctrl_pkg::TICK_W-1:0] ramp_base_in,
	input wire logic [led_ctrl_pkg::TICK_W-1:0] blink_base_in,
	output logic drive_on_out,
	output logic [LEVEL_W-1:0] level_out
);
	import led_ctrl_pkg::*;

	logic [TICK_W-1:0] ramp_cnt_ff;
	logic [TICK_W-1:0] nxt_ramp_cnt;
	logic [TICK_W-1:0] blink_cnt_ff;
	logic [TICK_W-1:0] nxt_blink_cnt;
	logic [LEVEL_W-1:0] level_ff;
	logic [LEVEL_W-1:0] nxt_level;
	logic blink_lit_ff;
	logic nxt_blink_lit;
	logic drive_ff;
	logic nxt_drive;
	wire blinking = HAS_BLINK && blink_enable_in;
	wire lit = !blinking || blink_lit_ff;
	wire [LEVEL_W-1:0] goal = (enable_in && lit) ? target_in : '0;
	wire rising = goal > level_ff;
	wire [TIMER_SEL_W-1:0] ramp_sel = rising ? ramp_up_sel_in
		: ramp_down_sel_in;
	wire [TIMER_SEL_W-1:0] blink_sel = blink_lit_ff ? blink_on_sel_in
		: blink_off_sel_in;
	wire [TICK_W-1:0] ramp_len = ramp_base_in << ramp_sel;
	wire [TICK_W-1:0] blink_len = blink_base_in << blink_sel;
	wire ramp_tick = ramp_cnt_ff >= ramp_len - 1'b1;
	wire blink_tick = blink_cnt_ff >= blink_len - 1'b1;

	// Ramp timer picks one of eight step intervals per direction; see RL5 RL6.
	assign nxt_ramp_cnt = (hold_in || goal == level_ff || ramp_tick) ? '0
		: ramp_cnt_ff + 1'b1;
	assign nxt_level = hold_in ? '0
		: (goal == level_ff || !ramp_tick) ? level_ff
		: rising ? level_ff + 1'b1 : level_ff - 1'b1;
	// Blink phases alternate only while blinking is enabled; see RL7.
	assign nxt_blink_cnt = (hold_in || !blinking || !enable_in || blink_tick)
		? '0 : blink_cnt_ff + 1'b1;
	assign nxt_blink_lit = (hold_in || !blinking || !enable_in) ? 1'b1
		: blink_tick ? !blink_lit_ff : blink_lit_ff;
	// A channel drives while enabled and in its lit phase; see RL8 RL12.
	assign nxt_drive = !hold_in && enable_in && lit;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ramp_cnt_ff <= '0;
			blink_cnt_ff <= '0;
			level_ff <= '0;
			blink_lit_ff <= 1'b1;
			drive_ff <= 1'b0;
		end
		else
		begin
			ramp_cnt_ff <= nxt_ramp_cnt;
			blink_cnt_ff <= nxt_blink_cnt;
			level_ff <= nxt_level;
			blink_lit_ff <= nxt_blink_lit;
			drive_ff <= nxt_drive;
		end
	end

	assign level_out = level_ff;
	assign drive_on_out = drive_ff;
endmodule

// [rtl/led_regulator_control.sv]
// Top of the LED regulator control plane: address recognition, channel
// sequencing, feedback selection, pulse-skip timing and fault status.
// Assumes channel voltages arrive as digital words on the core clock.
`timescale 1ns/1ns
module led_regulator_control #(
	parameter int RAMP_BASE = led_ctrl_pkg::RAMP_BASE_CYCLES,
	parameter int BLINK_BASE = led_ctrl_pkg::BLINK_BASE_CYCLES
) (
	input wire logic CORE_CLK_IN,
	input wire logic RST_N_IN,
	input wire logic SUPPLY_GOOD_IN,
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE_OUT,
	output logic WRITE_SELECT_OUT,
	output logic READ_SELECT_OUT,
	input wire logic [led_ctrl_pkg::NUM_CHAN-1:0] CHAN_ENABLE_IN,
	input wire logic [led_ctrl_pkg::HC_LEVEL_W-1:0] HC_LEVEL_A_IN,
	input wire logic [led_ctrl_pkg::HC_LEVEL_W-1:0] HC_LEVEL_B_IN,
	input wire logic [led_ctrl_pkg::LC_LEVEL_W-1:0] LC_LEVEL_A_IN,
	input wire logic [led_ctrl_pkg::LC_LEVEL_W-1:0] LC_LEVEL_B_IN,
	input wire logic [led_ctrl_pkg::LC_LEVEL_W-1:0] LC_LEVEL_C_IN,
	input wire logic [3*led_ctrl_pkg::NUM_CHAN-1:0] RAMP_UP_SEL_IN,
	input wire logic [3*led_ctrl_pkg::NUM_CHAN-1:0] RAMP_DOWN_SEL_IN,
	input wire logic [led_ctrl_pkg::NUM_LC-1:0] BLINK_ENABLE_IN,
	input wire logic [3*led_ctrl_pkg::NUM_LC-1:0] BLINK_ON_SEL_IN,
	input wire logic [3*led_ctrl_pkg::NUM_LC-1:0] BLINK_OFF_SEL_IN,
	input wire logic [led_ctrl_pkg::NUM_LC-1:0] SUPPLY_SOURCE_SELECT_IN,
	input wire logic [led_ctrl_pkg::VOLT_W*led_ctrl_pkg::NUM_CHAN-1:0]
		CHAN_VOLTAGE_IN,
	input wire logic LIGHT_LOAD_IN,
	input wire logic PULSE_DEMAND_IN,
	input wire logic PWM_ON_IN,
	input wire logic [led_ctrl_pkg::NUM_CHAN-1:0] LED_FAULT_IN,
	input wire logic OVP_FAULT_IN,
	input wire logic THERMAL_FAULT_IN,
	input wire logic DIODE_FAULT_IN,
	input wire logic STATUS_CLEAR_IN,
	output logic [led_ctrl_pkg::STATUS_W-1:0] STATUS_OUT,
	output logic CONVERTER_ON_OUT,
	output logic SWITCH_ON_OUT,
	output logic [led_ctrl_pkg::NUM_CHAN-1:0] FEEDBACK_SEL_OUT,
	output logic [led_ctrl_pkg::NUM_CHAN-1:0] CHAN_DRIVE_OUT,
	output logic [led_ctrl_pkg::HC_LEVEL_W-1:0] HC_LEVEL_A_OUT,
	output logic [led_ctrl_pkg::HC_LEVEL_W-1:0] HC_LEVEL_B_OUT,
	output logic [led_ctrl_pkg::LC_LEVEL_W-1:0] LC_LEVEL_A_OUT,
	output logic [led_ctrl_pkg::LC_LEVEL_W-1:0] LC_LEVEL_B_OUT,
	output logic [led_ctrl_pkg::LC_LEVEL_W-1:0] LC_LEVEL_C_OUT
);
	import led_ctrl_pkg::*;

	// Picks the lowest voltage among participants; ties go to the lower index.
	function automatic logic [NUM_CHAN-1:0] lowest_of(
		input logic [NUM_CHAN-1:0] part,
		input logic [VOLT_W*NUM_CHAN-1:0] volts);
		logic [NUM_CHAN-1:0] sel;
		logic [VOLT_W-1:0] best;
		logic found;
		sel = '0;
		best = '1;
		found = 1'b0;
		for (int i = 0; i < NUM_CHAN; i++)
		begin
			if (part[i] && (!found || volts[i*VOLT_W +: VOLT_W] < best))
			begin
				best = volts[i*VOLT_W +: VOLT_W];
				sel = '0;
				sel[i] = 1'b1;
				found = 1'b1;
			end
		end
		return sel;
	endfunction

	// Pin-side inputs pass two flip-flops before any logic sees them.
	localparam int SYNC_W = 4 + NUM_CHAN + 3 + 1;
	logic [SYNC_W-1:0] sync1_ff;
	logic [SYNC_W-1:0] sync2_ff;
	logic scl_d_ff;
	logic sda_d_ff;
	wire [SYNC_W-1:0] pins = {SUPPLY_GOOD_IN, SCL_IN, SDA_IN, PULSE_DEMAND_IN,
		LED_FAULT_IN, OVP_FAULT_IN, THERMAL_FAULT_IN, DIODE_FAULT_IN,
		LIGHT_LOAD_IN};
	wire supply_good = sync2_ff[SYNC_W-1];
	wire scl = sync2_ff[SYNC_W-2];
	wire sda = sync2_ff[SYNC_W-3];
	wire demand = sync2_ff[SYNC_W-4];
	wire [NUM_CHAN-1:0] led_fault = sync2_ff[SYNC_W-5 -: NUM_CHAN];
	wire ovp_fault = sync2_ff[3];
	wire thermal_fault = sync2_ff[2];
	wire diode_fault = sync2_ff[1];
	wire light_load = sync2_ff[0];
	// Shutdown acts as a synchronous clear of all state but the synchronisers, bus shift register and read/write flag; see RL13.
	wire hold = !supply_good;

	always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			sync1_ff <= {1'b0, 2'b11, {(SYNC_W-3){1'b0}}};
			sync2_ff <= {1'b0, 2'b11, {(SYNC_W-3){1'b0}}};
			scl_d_ff <= 1'b1;
			sda_d_ff <= 1'b1;
		end
		else
		begin
			sync1_ff <= pins;
			sync2_ff <= sync1_ff;
			scl_d_ff <= scl;
			sda_d_ff <= sda;
		end
	end

	// Address recognition on the serial bus.
	i2c_state_type i2c_state_ff;
	i2c_state_type nxt_i2c_state;
	logic [7:0] shift_ff;
	logic [7:0] nxt_shift;
	logic [3:0] bit_cnt_ff;
	logic [3:0] nxt_bit_cnt;
	logic wr_ff;
	logic nxt_wr;
	logic sda_oe_ff;
	wire scl_rise = scl && !scl_d_ff;
	wire scl_fall = !scl && scl_d_ff;
	wire bus_start = scl && scl_d_ff && sda_d_ff && !sda;
	wire bus_stop = scl && scl_d_ff && !sda_d_ff && sda;
	wire byte_done = scl_fall && bit_cnt_ff == I2C_BITS_PER_BYTE;
	wire addr_hit = shift_ff == I2C_ADDR_WRITE
		|| shift_ff == I2C_ADDR_READ; // see RL9
	wire selected = i2c_state_ff == I2C_ACK || i2c_state_ff == I2C_DATA;

	always_comb
	begin
		nxt_i2c_state = i2c_state_ff;
		nxt_shift = shift_ff;
		nxt_bit_cnt = bit_cnt_ff;
		nxt_wr = wr_ff;
		if (scl_rise)
		begin
			nxt_shift = {shift_ff[6:0], sda};
			nxt_bit_cnt = bit_cnt_ff + 4'h1;
		end
		unique case (i2c_state_ff)
			I2C_IDLE:
				nxt_bit_cnt = '0;
			I2C_ADDR:
				if (byte_done)
				begin
					nxt_i2c_state = addr_hit ? I2C_ACK : I2C_IDLE;
					nxt_wr = !shift_ff[0];
				end
			I2C_ACK:
				if (scl_fall)
				begin
					nxt_i2c_state = I2C_DATA;
					nxt_bit_cnt = '0;
				end
			I2C_DATA:
				// Written bytes are acknowledged; read data is not driven here.
				if (byte_done && wr_ff)
					nxt_i2c_state = I2C_ACK;
		endcase
		if (bus_start)
		begin
			nxt_i2c_state = I2C_ADDR;
			nxt_bit_cnt = '0;
		end
		else if (bus_stop || hold)
			nxt_i2c_state = I2C_IDLE;
	end

	always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			i2c_state_ff <= I2C_IDLE;
			shift_ff <= '0;
			bit_cnt_ff <= '0;
			wr_ff <= 1'b0;
			sda_oe_ff <= 1'b0;
		end
		else
		begin
			i2c_state_ff <= nxt_i2c_state;
			shift_ff <= nxt_shift;
			bit_cnt_ff <= nxt_bit_cnt;
			wr_ff <= nxt_wr;
			sda_oe_ff <= nxt_i2c_state == I2C_ACK;
		end
	end

	assign SDA_OUT = 1'b0;
	assign SDA_OE_OUT = sda_oe_ff;
	assign WRITE_SELECT_OUT = selected && wr_ff;
	assign READ_SELECT_OUT = selected && !wr_ff;

	// Five channel sequencers; blink exists on the low-current ones only.
	wire [TICK_W-1:0] ramp_base = TICK_W'(RAMP_BASE);
	wire [TICK_W-1:0] blink_base = TICK_W'(BLINK_BASE);
	wire [HC_LEVEL_W*NUM_HC-1:0] hc_target = {HC_LEVEL_B_IN, HC_LEVEL_A_IN};
	wire [LC_LEVEL_W*NUM_LC-1:0] lc_target =
		{LC_LEVEL_C_IN, LC_LEVEL_B_IN, LC_LEVEL_A_IN};
	wire [HC_LEVEL_W*NUM_HC-1:0] hc_level;
	wire [LC_LEVEL_W*NUM_LC-1:0] lc_level;

	for (genvar h = 0; h < NUM_HC; h++)
	begin : g_hc
		channel_sequencer #(.LEVEL_W(HC_LEVEL_W), .HAS_BLINK(1'b0)) u_seq (
			.clk(CORE_CLK_IN),
			.rst_n(RST_N_IN),
			.hold_in(hold),
			.enable_in(CHAN_ENABLE_IN[h]),
			.target_in(hc_target[h*HC_LEVEL_W +: HC_LEVEL_W]), // see RL3
			.ramp_up_sel_in(RAMP_UP_SEL_IN[h*3 +: 3]),
			.ramp_down_sel_in(RAMP_DOWN_SEL_IN[h*3 +: 3]),
			.blink_enable_in(1'b0),
			.blink_on_sel_in(3'h0),
			.blink_off_sel_in(3'h0),
			.ramp_base_in(ramp_base),
			.blink_base_in(blink_base),
			.drive_on_out(CHAN_DRIVE_OUT[h]),
			.level_out(hc_level[h*HC_LEVEL_W +: HC_LEVEL_W])
		);
	end

	for (genvar l = 0; l < NUM_LC; l++)
	begin : g_lc
		channel_sequencer #(.LEVEL_W(LC_LEVEL_W), .HAS_BLINK(1'b1)) u_seq (
			.clk(CORE_CLK_IN),
			.rst_n(RST_N_IN),
			.hold_in(hold),
			.enable_in(CHAN_ENABLE_IN[NUM_HC+l]),
			.target_in(lc_target[l*LC_LEVEL_W +: LC_LEVEL_W]), // see RL4
			.ramp_up_sel_in(RAMP_UP_SEL_IN[(NUM_HC+l)*3 +: 3]),
			.ramp_down_sel_in(RAMP_DOWN_SEL_IN[(NUM_HC+l)*3 +: 3]),
			.blink_enable_in(BLINK_ENABLE_IN[l]),
			.blink_on_sel_in(BLINK_ON_SEL_IN[l*3 +: 3]),
			.blink_off_sel_in(BLINK_OFF_SEL_IN[l*3 +: 3]),
			.ramp_base_in(ramp_base),
			.blink_base_in(blink_base),
			.drive_on_out(CHAN_DRIVE_OUT[NUM_HC+l]),
			.level_out(lc_level[l*LC_LEVEL_W +: LC_LEVEL_W])
		);
	end

	assign HC_LEVEL_A_OUT = hc_level[0 +: HC_LEVEL_W];
	assign HC_LEVEL_B_OUT = hc_level[HC_LEVEL_W +: HC_LEVEL_W];
	assign LC_LEVEL_A_OUT = lc_level[0 +: LC_LEVEL_W];
	assign LC_LEVEL_B_OUT = lc_level[LC_LEVEL_W +: LC_LEVEL_W];
	assign LC_LEVEL_C_OUT = lc_level[2*LC_LEVEL_W +: LC_LEVEL_W];

	// Feedback candidates: enabled, and not on the alternate supply.
	wire [NUM_CHAN-1:0] alt_mask = {SUPPLY_SOURCE_SELECT_IN, 2'b00}; // see RL2
	wire [NUM_CHAN-1:0] participate = CHAN_ENABLE_IN & ~alt_mask; // see RL15
	wire any_enabled = |CHAN_ENABLE_IN;
	logic [NUM_CHAN-1:0] fb_sel_ff;
	logic conv_on_ff;
	logic [STATUS_W-1:0] status_ff;
	logic [STATUS_W-1:0] nxt_status;
	wire [STATUS_W-1:0] fault_now = {diode_fault, thermal_fault, ovp_fault,
		led_fault & CHAN_ENABLE_IN};
	// A fault present in the clearing cycle stays flagged; see RL10.
	assign nxt_status = hold ? STATUS_RESET
		: ((STATUS_CLEAR_IN ? STATUS_RESET : status_ff) | fault_now);

	always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			fb_sel_ff <= '0;
			conv_on_ff <= 1'b0;
			status_ff <= STATUS_RESET;
		end
		else
		begin
			fb_sel_ff <= hold ? '0
				: lowest_of(participate, CHAN_VOLTAGE_IN); // see RL1
			conv_on_ff <= !hold && any_enabled; // see RL14 RL13
			status_ff <= nxt_status;
		end
	end

	assign FEEDBACK_SEL_OUT = fb_sel_ff;
	assign CONVERTER_ON_OUT = conv_on_ff;
	assign STATUS_OUT = status_ff;

	// Pulse skipping: a fixed minimum on-time, then off until demanded.
	skip_state_type skip_state_ff;
	skip_state_type nxt_skip_state;
	logic [1:0] on_cnt_ff;
	logic [1:0] nxt_on_cnt;
	logic switch_ff;
	wire on_done = on_cnt_ff == 2'(MIN_ON_CYCLES - 1);

	always_comb
	begin
		nxt_skip_state = skip_state_ff;
		nxt_on_cnt = '0;
		unique case (skip_state_ff)
			SKIP_IDLE:
				if (conv_on_ff && light_load && demand)
					nxt_skip_state = SKIP_ON;
			SKIP_ON:
			begin
				nxt_on_cnt = on_cnt_ff + 2'h1;
				if (on_done)
					nxt_skip_state = SKIP_IDLE; // see RL11
			end
		endcase
		if (hold)
			nxt_skip_state = SKIP_IDLE;
	end

	// The skip pulse can stretch a PWM pulse, never cut one short.
	always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			skip_state_ff <= SKIP_IDLE;
			on_cnt_ff <= '0;
			switch_ff <= 1'b0;
		end
		else
		begin
			skip_state_ff <= nxt_skip_state;
			on_cnt_ff <= nxt_on_cnt;
			switch_ff <= conv_on_ff && !hold && (nxt_skip_state == SKIP_ON
				|| (!light_load && PWM_ON_IN));
		end
	end

	assign SWITCH_ON_OUT = switch_ff;
endmodule

// [bench/led_regulator_control_properties.sv]
// Port checker for the LED regulator control top, attached by bind.
// Assumes the bench holds mode and supply pins steady for several cycles.
`timescale 1ns/1ns
module led_regulator_control_properties (
	input wire logic CORE_CLK_IN,
	input wire logic RST_N_IN,
	input wire logic SUPPLY_GOOD_IN,
	input wire logic [led_ctrl_pkg::NUM_CHAN-1:0] CHAN_ENABLE_IN,
	input wire logic [led_ctrl_pkg::NUM_LC-1:0] SUPPLY_SOURCE_SELECT_IN,
	input wire logic LIGHT_LOAD_IN,
	input wire logic PWM_ON_IN,
	input wire logic OVP_FAULT_IN,
	input wire logic STATUS_CLEAR_IN,
	input wire logic [led_ctrl_pkg::STATUS_W-1:0] STATUS_OUT,
	input wire logic CONVERTER_ON_OUT,
	input wire logic SWITCH_ON_OUT,
	input wire logic [led_ctrl_pkg::NUM_CHAN-1:0] FEEDBACK_SEL_OUT,
	input wire logic [led_ctrl_pkg::NUM_CHAN-1:0] CHAN_DRIVE_OUT,
	input wire logic SDA_OE_OUT,
	input wire logic WRITE_SELECT_OUT,
	input wire logic READ_SELECT_OUT,
	input wire logic [led_ctrl_pkg::HC_LEVEL_W-1:0] HC_LEVEL_A_OUT
);
	import led_ctrl_pkg::*;
	logic [3:0] sg_h_ff;
	logic [3:0] ll_h_ff;
	logic [4:0] cand;
	logic sg_up;
	logic sg_dn;
	// The pins pass synchronisers, so a level only counts once it is old.
	assign sg_up = SUPPLY_GOOD_IN && (sg_h_ff == 4'hf);
	assign sg_dn = !SUPPLY_GOOD_IN && (sg_h_ff == 4'h0);
	assign cand = CHAN_ENABLE_IN & ~{SUPPLY_SOURCE_SELECT_IN, 2'b00};
	always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			sg_h_ff <= 4'h0;
			ll_h_ff <= 4'h0;
		end
		else
		begin
			sg_h_ff <= {sg_h_ff[2:0], SUPPLY_GOOD_IN};
			ll_h_ff <= {ll_h_ff[2:0], LIGHT_LOAD_IN};
		end
	end
	default clocking cb @(posedge CORE_CLK_IN);
	endclocking
	default disable iff (!RST_N_IN);
	a_reset_quiet: assert property (
		$rose(RST_N_IN) |-> !CONVERTER_ON_OUT && !SDA_OE_OUT &&
		STATUS_OUT == 8'h00 && CHAN_DRIVE_OUT == 5'h00)
		else $error("outputs not quiet after reset");
	a_shutdown_quiet: assert property (
		sg_dn |-> !CONVERTER_ON_OUT && !SWITCH_ON_OUT &&
		CHAN_DRIVE_OUT == 5'h00 && FEEDBACK_SEL_OUT == 5'h00 &&
		STATUS_OUT == STATUS_RESET)
		else $error("outputs active in shutdown");
	a_conv_follow: assert property (
		sg_up |-> CONVERTER_ON_OUT == (|$past(CHAN_ENABLE_IN)))
		else $error("converter state does not follow enables");
	a_fb_allowed: assert property (
		sg_up |-> (FEEDBACK_SEL_OUT & ~$past(cand)) == 5'h00)
		else $error("feedback on masked or disabled channel");
	a_fb_onehot: assert property (
		sg_up |-> $onehot0(FEEDBACK_SEL_OUT) &&
		((FEEDBACK_SEL_OUT != 5'h00) == ($past(cand) != 5'h00)))
		else $error("feedback choice not single or missing");
	a_drive_follow: assert property (
		sg_up |-> CHAN_DRIVE_OUT[1:0] == $past(CHAN_ENABLE_IN[1:0]) &&
		(CHAN_DRIVE_OUT & ~$past(CHAN_ENABLE_IN)) == 5'h00)
		else $error("channel drive does not follow enable");
	a_ramp_step: assert property (
		sg_up |-> HC_LEVEL_A_OUT == $past(HC_LEVEL_A_OUT) ||
		HC_LEVEL_A_OUT == $past(HC_LEVEL_A_OUT) + 7'h01 ||
		HC_LEVEL_A_OUT == $past(HC_LEVEL_A_OUT) - 7'h01)
		else $error("level code jumped more than one step");
	a_skip_width: assert property (
		$rose(SWITCH_ON_OUT) && LIGHT_LOAD_IN && ll_h_ff == 4'hf &&
		CONVERTER_ON_OUT |=> SWITCH_ON_OUT ##1 !SWITCH_ON_OUT)
		else $error("skip pulse is not two cycles");
	a_pwm_follow: assert property (
		!LIGHT_LOAD_IN && ll_h_ff == 4'h0 && CONVERTER_ON_OUT &&
		$past(CONVERTER_ON_OUT) |-> SWITCH_ON_OUT == $past(PWM_ON_IN))
		else $error("switch does not follow pwm request");
	a_ack_selected: assert property (
		$rose(SDA_OE_OUT) |-> ##[0:2] (WRITE_SELECT_OUT || READ_SELECT_OUT))
		else $error("acknowledge without address match");
	a_sel_excl: assert property (
		!(WRITE_SELECT_OUT && READ_SELECT_OUT))
		else $error("write and read selected together");
	a_status_hold: assert property (
		sg_up && !$past(STATUS_CLEAR_IN) |->
		($past(STATUS_OUT[7:5]) & ~STATUS_OUT[7:5]) == 3'h0)
		else $error("status bit dropped without clear");
	a_ovp_set: assert property (
		sg_up && $rose(OVP_FAULT_IN) ##1 OVP_FAULT_IN[*2] |=>
		STATUS_OUT[STAT_OVP_POS])
		else $error("overvoltage status not set in time");
	c_fb_pick: cover property (FEEDBACK_SEL_OUT != 5'h00);
	c_skip: cover property ($rose(SWITCH_ON_OUT) && LIGHT_LOAD_IN);
	c_ack: cover property ($rose(SDA_OE_OUT));
endmodule
bind led_regulator_control led_regulator_control_properties props_i (
	.CORE_CLK_IN(CORE_CLK_IN), .RST_N_IN(RST_N_IN),
	.SUPPLY_GOOD_IN(SUPPLY_GOOD_IN), .CHAN_ENABLE_IN(CHAN_ENABLE_IN),
	.SUPPLY_SOURCE_SELECT_IN(SUPPLY_SOURCE_SELECT_IN),
	.LIGHT_LOAD_IN(LIGHT_LOAD_IN), .PWM_ON_IN(PWM_ON_IN),
	.OVP_FAULT_IN(OVP_FAULT_IN), .STATUS_CLEAR_IN(STATUS_CLEAR_IN),
	.STATUS_OUT(STATUS_OUT), .CONVERTER_ON_OUT(CONVERTER_ON_OUT),
	.SWITCH_ON_OUT(SWITCH_ON_OUT), .FEEDBACK_SEL_OUT(FEEDBACK_SEL_OUT),
	.CHAN_DRIVE_OUT(CHAN_DRIVE_OUT), .SDA_OE_OUT(SDA_OE_OUT),
	.WRITE_SELECT_OUT(WRITE_SELECT_OUT), .READ_SELECT_OUT(READ_SELECT_OUT),
	.HC_LEVEL_A_OUT(HC_LEVEL_A_OUT)
);

// [bench/i2c_host_model.sv]
// Host bus model: drives SCL and SDA and reads the device acknowledge.
// Assumes pull-ups on both lines; the device only ever pulls SDA low.
`timescale 1ns/1ns
module i2c_host_model (
	input wire logic clk_in,
	input wire logic sda_oe_in,
	output logic scl_out,
	output logic sda_out
);
	logic sda_drv_ff;
	// Open drain: the wire is low when either party pulls it.
	assign sda_out = sda_drv_ff & ~sda_oe_in;
	initial
	begin
		scl_out = 1'b1;
		sda_drv_ff = 1'b1;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	task automatic start_addr(input logic [7:0] adr, output logic acked);
		hold(1);
		sda_drv_ff <= 1'b0;
		hold(6);
		scl_out <= 1'b0;
		for (int i = 7; i >= 0; i--)
		begin
			hold(3);
			sda_drv_ff <= adr[i];
			hold(3);
			scl_out <= 1'b1;
			hold(6);
			scl_out <= 1'b0;
		end
		hold(3);
		sda_drv_ff <= 1'b1;
		hold(3);
		scl_out <= 1'b1;
		hold(3);
		acked = !sda_out;
		hold(3);
		scl_out <= 1'b0;
	endtask
	task automatic stop_bus();
		hold(3);
		sda_drv_ff <= 1'b0;
		hold(3);
		scl_out <= 1'b1;
		hold(6);
		sda_drv_ff <= 1'b1;
		hold(6);
	endtask
endmodule

// [bench/tb_top.sv]
// Self-checking bench for the LED regulator control top.
// Assumes short ramp and blink bases so every timer setting fits the run.
`timescale 1ns/1ns
module tb_top;
	import led_ctrl_pkg::*;
	localparam int RB = 2;
	localparam int BB = 4;
	logic clk, rst_n, sg, ll, dem, pwm, ovp, thm, dio, clr, ack;
	logic scl, sda, sda_oe, wsel, rsel, conv, sw;
	logic [4:0] en, fb, drv, lflt, lla, llb, llc, loa, lob, loc, l, f;
	logic [2:0] ben, mask;
	logic [14:0] rup, rdn;
	logic [8:0] bon, boff;
	logic [6:0] hla, hlb, hoa, hob, t;
	logic [39:0] volt;
	logic [7:0] stat;
	logic [7:0] adr [4] = '{8'h9a, 8'h9b, 8'h9c, 8'h1a};
	logic [28:0] lv;
	int err_total, n_compared, seed, na, nb, nc;
	assign lv = {loc, lob, loa, hob, hoa};
	led_regulator_control #(.RAMP_BASE(RB), .BLINK_BASE(BB))
		led_regulator_control_i (
		.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .SUPPLY_GOOD_IN(sg),
		.SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(), .SDA_OE_OUT(sda_oe),
		.WRITE_SELECT_OUT(wsel), .READ_SELECT_OUT(rsel),
		.CHAN_ENABLE_IN(en), .HC_LEVEL_A_IN(hla), .HC_LEVEL_B_IN(hlb),
		.LC_LEVEL_A_IN(lla), .LC_LEVEL_B_IN(llb), .LC_LEVEL_C_IN(llc),
		.RAMP_UP_SEL_IN(rup), .RAMP_DOWN_SEL_IN(rdn),
		.BLINK_ENABLE_IN(ben), .BLINK_ON_SEL_IN(bon),
		.BLINK_OFF_SEL_IN(boff), .SUPPLY_SOURCE_SELECT_IN(mask),
		.CHAN_VOLTAGE_IN(volt), .LIGHT_LOAD_IN(ll),
		.PULSE_DEMAND_IN(dem), .PWM_ON_IN(pwm), .LED_FAULT_IN(lflt),
		.OVP_FAULT_IN(ovp), .THERMAL_FAULT_IN(thm),
		.DIODE_FAULT_IN(dio), .STATUS_CLEAR_IN(clr), .STATUS_OUT(stat),
		.CONVERTER_ON_OUT(conv), .SWITCH_ON_OUT(sw),
		.FEEDBACK_SEL_OUT(fb), .CHAN_DRIVE_OUT(drv),
		.HC_LEVEL_A_OUT(hoa), .HC_LEVEL_B_OUT(hob),
		.LC_LEVEL_A_OUT(loa), .LC_LEVEL_B_OUT(lob), .LC_LEVEL_C_OUT(loc)
	);
	i2c_host_model i2c_host_model_i (.clk_in(clk), .sda_oe_in(sda_oe),
		.scl_out(scl), .sda_out(sda));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wrap_up();
		if (err_total == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic check(input string what, input logic [39:0] exp,
		input logic [39:0] got);
		n_compared++;
		if (exp !== got)
		begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Ties keep the lower channel because the compare is strict.
	function automatic logic [4:0] exp_fb(input logic [4:0] c,
		input logic [39:0] v);
		logic [4:0] r;
		logic [7:0] best;
		r = 5'h00;
		best = 8'hff;
		for (int i = 0; i < 5; i++)
			if (c[i] && (r == 5'h00 || v[8*i+:8] < best))
			begin
				r = 5'h01 << i;
				best = v[8*i+:8];
			end
		return r;
	endfunction
	task automatic settle(input logic [28:0] goal, input int iv,
		input int st);
		int n;
		n = 0;
		while (lv !== goal && n < 40000)
		begin
			tick(1);
			n++;
		end
		check("ramp level", 40'(goal), 40'(lv));
		check("ramp time", 40'(n > (st - 1) * iv && n <= st * iv + 4),
			40'(1));
		if (n >= 40000)
			wrap_up();
	endtask
	initial
	begin
		tick(90000);
		err_total++;
		wrap_up();
	end
	initial
	begin
		seed = 75029;
		{rst_n, ll, dem, pwm, ovp, thm, dio, clr, en, lflt} = '0;
		{ben, mask, rup, rdn, bon, boff, volt} = '0;
		{hla, hlb, lla, llb, llc} = '0;
		sg = 1'b1;
		tick(4);
		rst_n <= 1'b1;
		tick(6);
		foreach (adr[i])
		begin
			i2c_host_model_i.start_addr(adr[i], ack);
			check("ack", 40'(adr[i] == I2C_ADDR_WRITE ||
				adr[i] == I2C_ADDR_READ), 40'(ack));
			check("wsel", 40'(adr[i] == I2C_ADDR_WRITE), 40'(wsel));
			check("rsel", 40'(adr[i] == I2C_ADDR_READ), 40'(rsel));
			i2c_host_model_i.stop_bus();
			check("released", 40'(0), 40'({wsel, rsel}));
		end
		for (int k = 0; k < 40; k++)
		begin
			en <= (k == 5) ? 5'h1c : 5'($random(seed));
			mask <= (k == 5) ? 3'h7 : 3'($random(seed));
			volt <= (k < 5) ? {5{8'h40}} : {$random(seed), 8'($random(seed))};
			tick(2);
			check("fb", 40'(exp_fb(en & ~{mask, 2'b00}, volt)),
				40'(fb));
			check("drive", 40'(en), 40'(drv));
			check("conv", 40'(|en), 40'(conv));
		end
		for (int s = 0; s < 8; s++)
		begin
			t = (s == 0) ? 7'h7f : 7'(1 + ($random(seed) & 7));
			l = (s == 0) ? 5'h1f : t[4:0];
			{hla, hlb, lla, llb, llc} <= {t, t, l, l, l};
			rup <= {5{3'(s)}};
			rdn <= {5{3'(7 - s)}};
			en <= 5'h1f;
			settle({l, l, l, t, t}, RB << s, int'(t));
			en <= 5'h00;
			settle(29'h0, RB << (7 - s), int'(t));
		end
		ben <= 3'b101;
		bon <= 9'h040;
		boff <= 9'h001;
		en <= 5'h1c;
		tick(3);
		{na, nb, nc} = '0;
		repeat (48)
		begin
			tick(1);
			na += (drv[2] === 1'b1);
			nb += (drv[3] === 1'b1);
			nc += (drv[4] === 1'b1);
		end
		check("blink a", 40'(16), 40'(na));
		check("blink off", 40'(48), 40'(nb));
		check("blink c", 40'(32), 40'(nc));
		ben <= 3'b000;
		en <= 5'h01;
		ll <= 1'b1;
		tick(6);
		dem <= 1'b1;
		tick(1);
		dem <= 1'b0;
		na = 0;
		repeat (12)
		begin
			tick(1);
			na += (sw === 1'b1);
		end
		check("skip width", 40'(2), 40'(na));
		ll <= 1'b0;
		tick(6);
		repeat (10)
		begin
			pwm <= 1'($random(seed));
			tick(2);
			check("pwm", 40'(pwm), 40'(sw));
		end
		pwm <= 1'b0;
		en <= 5'h13;
		f = 5'($random(seed));
		{lflt, ovp, thm, dio} <= {f, 3'b111};
		tick(5);
		{lflt, ovp, thm, dio} <= '0;
		tick(3);
		check("status", 40'({3'b111, f & 5'h13}), 40'(stat));
		clr <= 1'b1;
		tick(1);
		clr <= 1'b0;
		tick(2);
		check("status clear", 40'(0), 40'(stat));
		ovp <= 1'b1;
		tick(5);
		clr <= 1'b1;
		tick(1);
		{clr, ovp} <= 2'b00;
		tick(1);
		check("status set wins", 40'(1) << STAT_OVP_POS, 40'(stat));
		en <= 5'h1f;
		sg <= 1'b0;
		tick(6);
		check("shutdown", 40'(0), 40'({conv, sw, drv, fb, stat}));
		sg <= 1'b1;
		tick(6);
		check("restart", 40'(1), 40'(conv));
		rst_n <= 1'b0;
		tick(2);
		check("reset", 40'(0), 40'({conv, drv, stat, sda_oe}));
		rst_n <= 1'b1;
		tick(4);
		wrap_up();
	end
endmodule
